// [include/dmats_pkg.sv]
// Shared constants and types for the DMA sequencer and its bus host
package dmats_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int NUM_CTRL = 21;
  localparam int NUM_STAT = 7;
  localparam int REG_W    = 8;
  localparam int ADDR_W   = 16;
  localparam int IDX_W    = 5;

  // ----------------------------------------------------------------
  // Device control register indices (write side)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] C_CMD   = 5'h00;
  localparam logic [IDX_W-1:0] C_CLASS = 5'h01;
  localparam logic [IDX_W-1:0] C_MODE  = 5'h02;
  localparam logic [IDX_W-1:0] C_STEP  = 5'h03;
  localparam logic [IDX_W-1:0] C_ASTL  = 5'h04;
  localparam logic [IDX_W-1:0] C_ASTH  = 5'h05;
  localparam logic [IDX_W-1:0] C_BSTL  = 5'h06;
  localparam logic [IDX_W-1:0] C_BSTH  = 5'h07;
  localparam logic [IDX_W-1:0] C_LENL  = 5'h08;
  localparam logic [IDX_W-1:0] C_LENH  = 5'h09;
  localparam logic [IDX_W-1:0] C_MATCH = 5'h0A;
  localparam logic [IDX_W-1:0] C_MASK  = 5'h0B;

  // ----------------------------------------------------------------
  // Device status register indices (read side)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] S_GEN  = 5'h00;
  localparam logic [IDX_W-1:0] S_CNTL = 5'h01;
  localparam logic [IDX_W-1:0] S_CNTH = 5'h02;
  localparam logic [IDX_W-1:0] S_AL   = 5'h03;
  localparam logic [IDX_W-1:0] S_AH   = 5'h04;
  localparam logic [IDX_W-1:0] S_BL   = 5'h05;
  localparam logic [IDX_W-1:0] S_BH   = 5'h06;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_EN   = 0;
  localparam int CMD_DIS  = 1;
  localparam int CMD_LOAD = 2;
  localparam int CMD_CLR  = 3;
  localparam int CL_XFER  = 0;
  localparam int CL_SRCH  = 1;
  localparam int CL_SIMUL = 2;
  localparam int CL_ASRC  = 3;
  localparam int CL_AIO   = 4;
  localparam int CL_BIO   = 5;
  localparam int MD_LO    = 0;
  localparam int MD_FRDY  = 2;
  localparam int MD_STOPM = 3;
  localparam int MD_INTM  = 4;
  localparam int MD_INTE  = 5;
  localparam int STP_A    = 0;
  localparam int STP_B    = 2;
  localparam int ST_RDY   = 0;
  localparam int ST_EOB   = 1;
  localparam int ST_MTCH  = 2;
  localparam int ST_INT   = 3;
  localparam int ST_ENA   = 4;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_BYTE  = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_CONT  = 2'h2;
  localparam logic [1:0] STEP_INC   = 2'h1;
  localparam logic [1:0] STEP_DEC   = 2'h2;
  localparam logic [REG_W-1:0]  RST_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Host APB map
  // ----------------------------------------------------------------
  localparam logic [11:0] H_CMD  = 12'h000;
  localparam logic [11:0] H_STAT = 12'h004;
  localparam logic [11:0] H_LEN  = 12'h008;
  localparam int HC_IDX = 0;
  localparam int HC_DAT = 8;
  localparam int HC_WR  = 16;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_REQ, ST_SSTEP, ST_RD, ST_DSTEP, ST_WR, ST_FLY,
    ST_END, ST_WAIT, ST_REL, ST_GAP
  } dmats_state_e;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ACC, H_CAP} dmats_hstate_e;

endpackage

// [include/dmats_if.sv]
// System bus and register port joining the DMA sequencer and its host
`timescale 1ns/1ps
interface dmats_if;
  import dmats_pkg::*;

  // Bus ownership handshake and device interrupt
  logic              bus_req;
  logic              bus_ack;
  logic              host_oe;
  logic              dev_int;
  // Device-driven system bus
  logic [ADDR_W-1:0] dev_addr;
  logic              dev_aoe;
  logic [7:0]        dev_dout;
  logic              dev_doe;
  logic              dev_mreq;
  logic              dev_iorq;
  logic              dev_rd;
  logic              dev_wr;
  // Resolved data bus level and port ready, both from the bench
  logic [7:0]        sys_din;
  logic              port_ready;
  // Register access port
  logic              reg_sel;
  logic              reg_wr;
  logic [IDX_W-1:0]  reg_idx;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata;

  modport dev (
    output bus_req, dev_int, dev_addr, dev_aoe, dev_dout, dev_doe,
    output dev_mreq, dev_iorq, dev_rd, dev_wr, reg_rdata,
    input  bus_ack, sys_din, port_ready, reg_sel, reg_wr, reg_idx,
    input  reg_wdata
  );

  modport host (
    output bus_ack, host_oe, reg_sel, reg_wr, reg_idx, reg_wdata,
    input  bus_req, dev_int, reg_rdata
  );
endinterface

// [hdl/dmats_device.sv]
// DMA sequencer: transfer, search and bus mastering engine
//
// Function
// [R1] 21 writable control, 7 readable status bytes
// [R2] Register access only while not owning bus
// [R3] Status: ready, end, match, interrupt, counters
// [R4] Transfer, search, or both; sequential or simultaneous
// [R5] Device drives address, data, control while owning
// [R6] Sequential: read into holder, then write it
// [R7] Simultaneous: read and write in one cycle
// [R8] Simultaneous only between memory and I/O
// [R9] Search compares unmasked bits with match byte
// [R10] Forced ready acts as active port ready
// [R11] Byte mode releases bus after each byte
// [R12] Burst holds bus until ready, end, match
// [R13] Burst re-requests bus once ready returns
// [R14] Continuous holds bus, idles while ready low
// [R15] A byte once read always completes
// [R16] Step source, read, step destination, write, compare
// [R17] No match counts on; match sets flag, acts
// [R18] Start needs enable and ready, then request
// [R19] Host acknowledges request and frees the bus
// [R20] End when count reaches length; flag, stop
// [R21] Byte mode leaves host one cycle between
// [R22] Length register holds desired count minus one
// [R23] Release drops request and floats all drivers
`timescale 1ns/1ps
module dmats_device
  import dmats_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // System bus and register port
  dmats_if.dev      b,
  // User side
  output logic      dma_active
);
  import dmats_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [REG_W-1:0]  ctrl [NUM_CTRL];
  dmats_state_e      state;
  dmats_state_e      next_state;
  logic [ADDR_W-1:0] a_addr;
  logic [ADDR_W-1:0] b_addr;
  logic [ADDR_W-1:0] count;
  logic [7:0]        hold;
  logic              enabled;
  logic              st_eob;
  logic              st_match;
  logic              st_int;

  // Address step by the port's counting rule
  function automatic logic [ADDR_W-1:0] step(
    input logic [ADDR_W-1:0] addr,
    input logic [1:0]        rule
  );
    if (rule == STEP_INC) begin
      step = addr + 16'h0001;
    end else if (rule == STEP_DEC) begin
      step = addr - 16'h0001;
    end else begin
      step = addr;
    end
  endfunction

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire [7:0] cls    = ctrl[C_CLASS];
  wire [7:0] mode   = ctrl[C_MODE];
  wire [1:0] mode_k = mode[MD_LO +: 2];
  wire       a_src  = cls[CL_ASRC];
  wire       src_io = a_src ? cls[CL_AIO] : cls[CL_BIO];
  wire       dst_io = a_src ? cls[CL_BIO] : cls[CL_AIO];
  wire       simul  = cls[CL_SIMUL] & (cls[CL_AIO] ^ cls[CL_BIO]); // see R8
  wire       search = cls[CL_SRCH];
  wire       xfer   = cls[CL_XFER] | ~cls[CL_SRCH];               // see R4
  wire       eff_rdy = b.port_ready | mode[MD_FRDY];              // see R10
  wire       owning = ~(state inside {ST_IDLE, ST_REQ}) | b.bus_ack;
  wire       reg_ok = b.reg_sel & ~owning;                        // see R2
  wire       wr_ok  = reg_ok & b.reg_wr;
  wire       rd_ok  = reg_ok & ~b.reg_wr;
  wire       cmd_wr = wr_ok & (b.reg_idx == C_CMD);
  wire [7:0] cmd    = b.reg_wdata;
  wire [ADDR_W-1:0] blen = {ctrl[C_LENH], ctrl[C_LENL]};

  // Masked compare: a mask bit of one leaves that bit out
  wire is_match = search &
    (((hold ^ ctrl[C_MATCH]) & ~ctrl[C_MASK]) == 8'h00);          // see R9
  wire is_eob   = (count == blen);                                // see R20, R22
  wire stop_now = is_eob | (is_match & mode[MD_STOPM]);
  wire int_now  = (is_eob & mode[MD_INTE]) | (is_match & mode[MD_INTM]);

  // Address counters after this cycle's step
  wire step_a = ((state == ST_SSTEP) & a_src) |
                ((state == ST_DSTEP) & ~a_src);
  wire step_b = ((state == ST_SSTEP) & ~a_src) |
                ((state == ST_DSTEP) & a_src);
  wire [ADDR_W-1:0] a_next =
    step_a ? step(a_addr, ctrl[C_STEP][STP_A +: 2]) : a_addr;
  wire [ADDR_W-1:0] b_next =
    step_b ? step(b_addr, ctrl[C_STEP][STP_B +: 2]) : b_addr;
  wire [ADDR_W-1:0] src_addr = a_src ? a_next : b_next;
  wire [ADDR_W-1:0] dst_addr = a_src ? b_next : a_next;
  wire [ADDR_W-1:0] mem_addr = cls[CL_AIO] ? b_next : a_next;

  // Status byte and read mux
  wire [7:0] gen_stat = {3'h0, enabled, st_int, st_match, st_eob, eff_rdy};
  logic [7:0] stat_mux;
  always_comb begin
    case (b.reg_idx)
      S_GEN:   stat_mux = gen_stat;                               // see R3
      S_CNTL:  stat_mux = count[7:0];
      S_CNTH:  stat_mux = count[15:8];
      S_AL:    stat_mux = a_addr[7:0];
      S_AH:    stat_mux = a_addr[15:8];
      S_BL:    stat_mux = b_addr[7:0];
      S_BH:    stat_mux = b_addr[15:8];
      default: stat_mux = RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state of the per-byte engine
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enabled & eff_rdy) begin                              // see R18, R13
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (b.bus_ack) begin
          next_state = ST_SSTEP;
        end
      end
      ST_SSTEP: next_state = simul ? ST_DSTEP : ST_RD;            // see R16
      ST_RD:    next_state = xfer ? ST_DSTEP : ST_END;
      ST_DSTEP: next_state = simul ? ST_FLY : ST_WR;
      ST_WR:    next_state = ST_END;                              // see R15
      ST_FLY:   next_state = ST_END;
      ST_END: begin
        if (stop_now) begin
          next_state = ST_REL;                                    // see R17, R20
        end else if (mode_k == MODE_BYTE) begin
          next_state = ST_REL;                                    // see R11
        end else if (eff_rdy) begin
          next_state = ST_SSTEP;                                  // see R12
        end else if (mode_k == MODE_CONT) begin
          next_state = ST_WAIT;                                   // see R14
        end else begin
          next_state = ST_REL;                                    // see R12
        end
      end
      ST_WAIT: begin
        if (eff_rdy) begin
          next_state = ST_SSTEP;                                  // see R14
        end
      end
      ST_REL: begin
        if (!b.bus_ack) begin
          next_state = ST_GAP;                                    // see R23
        end
      end
      ST_GAP:  next_state = ST_IDLE;                              // see R21
      default: next_state = ST_IDLE;
    endcase
  end

  // Bus outputs decoded from the coming state
  wire n_hold = (next_state inside {ST_SSTEP, ST_RD, ST_DSTEP, ST_WR,
                                    ST_FLY, ST_END, ST_WAIT});
  wire n_req  = n_hold | (next_state == ST_REQ);
  wire n_rd   = (next_state == ST_RD) | (next_state == ST_FLY);
  wire n_wr   = (next_state == ST_WR) | (next_state == ST_FLY);
  wire n_mreq = ((next_state == ST_RD) & ~src_io) |
                ((next_state == ST_WR) & ~dst_io) | (next_state == ST_FLY);
  wire n_iorq = ((next_state == ST_RD) & src_io) |
                ((next_state == ST_WR) & dst_io) | (next_state == ST_FLY);
  wire [ADDR_W-1:0] n_addr = (next_state == ST_RD)  ? src_addr :
                             (next_state == ST_WR)  ? dst_addr :
                             (next_state == ST_FLY) ? mem_addr : b.dev_addr;

  // State and bus output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      b.bus_req  <= 1'b0;
      b.dev_aoe  <= 1'b0;
      b.dev_addr <= RST_WORD;
      b.dev_doe  <= 1'b0;
      b.dev_dout <= RST_BYTE;
      b.dev_mreq <= 1'b0;
      b.dev_iorq <= 1'b0;
      b.dev_rd   <= 1'b0;
      b.dev_wr   <= 1'b0;
      dma_active <= 1'b0;
    end else begin
      state      <= next_state;
      b.bus_req  <= n_req;                                        // see R18, R23
      b.dev_aoe  <= n_hold;                                       // see R5, R23
      b.dev_addr <= n_addr;
      b.dev_doe  <= (next_state == ST_WR);                        // see R6
      b.dev_dout <= hold;                                         // see R6
      b.dev_mreq <= n_mreq;
      b.dev_iorq <= n_iorq;
      b.dev_rd   <= n_rd;                                         // see R7
      b.dev_wr   <= n_wr;                                         // see R7
      dma_active <= n_hold;
    end
  end

  // ----------------------------------------------------------------
  // Datapath and status
  // ----------------------------------------------------------------
  // Control bytes; the command index acts and is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctrl[i] <= RST_BYTE;
      end
    end else if (wr_ok && !cmd_wr) begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        if (b.reg_idx == IDX_W'(i)) begin
          ctrl[i] <= b.reg_wdata;                                 // see R1
        end
      end
    end
  end

  // Counters, holding byte, enable and sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_addr      <= RST_WORD;
      b_addr      <= RST_WORD;
      count       <= RST_WORD;
      hold        <= RST_BYTE;
      enabled     <= 1'b0;
      st_eob      <= 1'b0;
      st_match    <= 1'b0;
      st_int      <= 1'b0;
      b.reg_rdata <= RST_BYTE;
    end else begin
      a_addr <= a_next;                                           // see R16
      b_addr <= b_next;
      if (rd_ok) begin
        b.reg_rdata <= stat_mux;                                  // see R3
      end
      if (state == ST_RD || state == ST_FLY) begin
        hold <= b.sys_din;
      end
      if (cmd_wr) begin
        if (cmd[CMD_LOAD]) begin
          a_addr <= {ctrl[C_ASTH], ctrl[C_ASTL]};
          b_addr <= {ctrl[C_BSTH], ctrl[C_BSTL]};
          count  <= RST_WORD;
        end
        if (cmd[CMD_CLR]) begin
          st_eob   <= 1'b0;
          st_match <= 1'b0;
          st_int   <= 1'b0;
        end
        if (cmd[CMD_EN]) begin
          enabled <= 1'b1;
        end
        if (cmd[CMD_DIS]) begin
          enabled <= 1'b0;
        end
      end
      // Flags set after the clear so a coinciding set wins
      if (state == ST_END) begin
        if (!is_eob) begin
          count <= count + 16'h0001;                              // see R17
        end
        if (is_eob) begin
          st_eob <= 1'b1;                                         // see R20
        end
        if (is_match) begin
          st_match <= 1'b1;                                       // see R17
        end
        if (int_now) begin
          st_int <= 1'b1;
        end
        if (stop_now) begin
          enabled <= 1'b0;
        end
      end
    end
  end

  // Interrupt pending straight from its flag
  assign b.dev_int = st_int;

endmodule

// [hdl/dmats_host.sv]
// Bus host: grants the system bus and runs device register accesses
`timescale 1ns/1ps
module dmats_host
  import dmats_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System bus side
  dmats_if.host            b
);
  import dmats_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmats_hstate_e hstate;
  dmats_hstate_e next_h;
  logic       ack;
  logic       gap;
  logic [7:0] last_rd;
  logic [IDX_W-1:0] cur_idx;
  logic [7:0] cur_dat;
  logic       cur_wr;
  logic       sec;
  logic [7:0] sec_dat;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire setup   = psel & ~penable;
  wire wr_take = psel & penable & pready & pwrite;
  wire idle    = (hstate == H_IDLE);
  wire go_cmd  = wr_take & (paddr == H_CMD) & idle;
  wire go_len  = wr_take & (paddr == H_LEN) & idle;
  wire free    = ~b.bus_req & ~ack & ~gap;                        // see R2
  wire [15:0] len_m1 = pwdata[15:0] - 16'h0001;                   // see R22
  wire [31:0] stat = {16'h0000, last_rd, 5'h00, b.dev_int, ack, ~idle};
  wire [31:0] rd_mux = (paddr == H_STAT) ? stat : 32'h0000_0000;
  // Grant only when the device asks and no register access runs
  wire next_ack = ack ? b.bus_req :
    (b.bus_req & ~gap & (hstate == H_IDLE || hstate == H_WAIT)); // see R19, R21

  // Access sequencer next state
  always_comb begin
    next_h = hstate;
    case (hstate)
      H_IDLE: begin
        if (go_cmd || go_len) begin
          next_h = H_WAIT;
        end
      end
      H_WAIT: begin
        if (free) begin
          next_h = H_ACC;                                         // see R2
        end
      end
      H_ACC:   next_h = H_CAP;
      H_CAP:   next_h = sec ? H_WAIT : H_IDLE;
      default: next_h = H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Flops
  // ----------------------------------------------------------------
  // APB answer, one access cycle, never an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Bus grant, host drivers and register port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate      <= H_IDLE;
      ack         <= 1'b0;
      gap         <= 1'b0;
      b.bus_ack   <= 1'b0;
      b.host_oe   <= 1'b1;
      b.reg_sel   <= 1'b0;
      b.reg_wr    <= 1'b0;
      b.reg_idx   <= 5'h00;
      b.reg_wdata <= 8'h00;
      last_rd     <= 8'h00;
      cur_idx     <= 5'h00;
      cur_dat     <= 8'h00;
      cur_wr      <= 1'b0;
      sec         <= 1'b0;
      sec_dat     <= 8'h00;
    end else begin
      hstate      <= next_h;
      ack         <= next_ack;
      gap         <= ack & ~b.bus_req;                            // see R21
      b.bus_ack   <= next_ack;                                    // see R19
      b.host_oe   <= ~next_ack;                                   // see R19
      b.reg_sel   <= (next_h == H_ACC);
      b.reg_wr    <= cur_wr;
      b.reg_idx   <= cur_idx;
      b.reg_wdata <= cur_dat;
      if (hstate == H_CAP && !cur_wr) begin
        last_rd <= b.reg_rdata;
      end
      if (go_cmd) begin
        cur_idx <= pwdata[HC_IDX +: IDX_W];
        cur_dat <= pwdata[HC_DAT +: 8];
        cur_wr  <= pwdata[HC_WR];
      end
      if (go_len) begin
        cur_idx <= C_LENL;
        cur_dat <= len_m1[7:0];
        cur_wr  <= 1'b1;
        sec     <= 1'b1;
        sec_dat <= len_m1[15:8];
      end
      if (hstate == H_CAP && sec) begin
        cur_idx <= C_LENH;
        cur_dat <= sec_dat;
        sec     <= 1'b0;
      end
    end
  end

endmodule

// [sim/dmats_sva.sv]
// Bus ownership and strobe checks for the DMA pair
`timescale 1ns/1ps
module dmats_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched bus signals
  input wire logic bus_req,
  input wire logic bus_ack,
  input wire logic host_oe,
  input wire logic dev_aoe,
  input wire logic dev_doe,
  input wire logic dev_rd,
  input wire logic dev_wr,
  input wire logic reg_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Strobes only under grant
  drive_own_a: assert property ((dev_rd || dev_wr) |-> dev_aoe && bus_ack)
    else $error("strobe without grant");
  doe_write_a: assert property (dev_doe |-> dev_wr && dev_aoe)
    else $error("data driven outside write");
  seq_order_a: assert property (dev_doe |-> $past(dev_rd, 2) && !dev_rd)
    else $error("write not after read");
  // Release and grant handshake
  rel_float_a: assert property ($fell(bus_req) |-> !dev_aoe && !dev_doe)
    else $error("drivers on at release");
  ack_drop_a: assert property ($fell(bus_req) |=> !bus_ack)
    else $error("grant held after release");
  host_gap_a: assert property ($fell(bus_ack) |-> !bus_ack [*2])
    else $error("no host cycle between");
  grant_a: assert property ($rose(bus_req) |-> ##[1:16] bus_ack)
    else $error("request not granted");
  host_off_a: assert property (bus_ack && $past(bus_ack) |-> !host_oe)
    else $error("host drives while granted");
  reg_idle_a: assert property (reg_sel |-> !bus_ack && !dev_aoe)
    else $error("register access while owning");
endmodule

// [sim/tb.sv]
// Self-checking bench joining the DMA sequencer and its host
`timescale 1ns/1ps
module tb;
  import dmats_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [7:0]  key = 8'h00;
  logic        rd_seen = 1'b0;
  logic        req_q = 1'b0;
  int          reqs = 0;
  int          n;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [23:0] wq[$];
  logic [7:0]  rq[$];
  dmats_if bus_if ();
  // Clock and data bus level
  always #2.5 pclk = ~pclk;
  assign bus_if.sys_din = bus_if.dev_addr[7:0] ^ key;
  dmats_device dmats_device_i (.pclk(pclk), .presetn(presetn),
    .b(bus_if.dev), .dma_active());
  dmats_host dmats_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .b(bus_if.host));
  dmats_sva dmats_sva_i (.pclk(pclk), .presetn(presetn),
    .bus_req(bus_if.bus_req), .bus_ack(bus_if.bus_ack),
    .host_oe(bus_if.host_oe), .dev_aoe(bus_if.dev_aoe),
    .dev_doe(bus_if.dev_doe), .dev_rd(bus_if.dev_rd),
    .dev_wr(bus_if.dev_wr), .reg_sel(bus_if.reg_sel));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task tmo(input int c);
    if (c >= 3000) begin
      error_cnt++;
      $display("MISMATCH wait expected done seen timeout");
      print_verdict;
    end
  endtask
  task cmp(input string nm, input logic [23:0] e, input logic [23:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int c;
    c = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 3000);
    tmo(c);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task busy;
    logic [31:0] r;
    int c;
    c = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && c < 3000) begin
      apb(1'b0, H_STAT, 32'h0, r);
      c++;
    end
    tmo(c);
  endtask
  task dw(input logic [4:0] i, input logic [7:0] v, input logic w = 1'b1);
    logic [31:0] r;
    apb(1'b1, H_CMD, {15'h0000, w, v, 3'h0, i}, r);
    busy();
  endtask
  task dr(input logic [4:0] i, input logic [7:0] e);
    rq.push_back(e);
    dw(i, 8'h00, 1'b0);
  endtask
  task run(input logic [7:0] cl, md, st, input logic [15:0] sa, ln);
    logic [31:0] r;
    dw(C_CLASS, cl);
    dw(C_MODE, md);
    dw(C_STEP, st);
    dw(C_ASTL, sa[7:0]);
    dw(C_ASTH, sa[15:8]);
    dw(C_BSTL, 8'h00);
    dw(C_BSTH, 8'h30);
    apb(1'b1, H_LEN, {16'h0000, ln}, r);
    busy();
    dw(C_CMD, 8'h0C);
    dw(C_CMD, 8'h01);
  endtask
  // Result watcher
  always @(posedge pclk) begin
    rd_seen <= bus_if.reg_sel & ~bus_if.reg_wr;
    req_q <= bus_if.bus_req;
    if (bus_if.bus_req === 1'b1 && req_q === 1'b0)
      reqs++;
    if (rd_seen)
      cmp("reg_rdata", {16'h0, rq.pop_front()}, {16'h0, bus_if.reg_rdata});
    if (bus_if.dev_wr === 1'b1 &&
        (bus_if.dev_doe === 1'b1 || bus_if.dev_rd === 1'b1))
      cmp("write", wq.pop_front(), {bus_if.dev_addr, bus_if.dev_doe ?
          bus_if.dev_dout : bus_if.sys_din});
  end
  // Main sequence
  initial begin
    bus_if.port_ready = 1'b0;
    void'($urandom(39546));
    key = 8'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Modes 0..2 sequential; pass 3 flyby from memory A to I/O B
    for (int m = 0; m < 4; m++) begin
      for (int k = 1; k <= 4; k++)
        wq.push_back({(m == 3 ? 16'h1000 : 16'h3000) + 16'(k), 8'(k) ^ key});
      run(m == 3 ? 8'h2D : 8'h09, {2'h0, 1'b1, 2'h0, m == 0, 2'(m)}, 8'h05,
          16'h1000, 16'h0004);
      n = 0;
      while ((wq.size() > 0 || bus_if.bus_req !== 1'b0) && n < 3000) begin
        @(posedge pclk);
        bus_if.port_ready <= 1'($urandom);
        n++;
      end
      tmo(n);
      bus_if.port_ready <= 1'b0;
      dr(S_GEN, 8'h0A | 8'(m == 0));
      dr(S_CNTL, 8'h03);
      dr(S_AL, 8'h04);
      $display("copy test mode %0d done", m);
    end
    bus_if.port_ready <= 1'b1;
    dw(C_MATCH, 8'hFC ^ key);
    dw(C_MASK, 8'h01);
    reqs = 0;
    run(8'h0A, 8'h08, 8'h02, 16'h2000, 16'h0010);
    n = 0;
    while ((reqs < 3 || bus_if.bus_req !== 1'b0) && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    tmo(n);
    repeat (40) @(posedge pclk);
    cmp("bus requests", 24'h000003, 24'(reqs));
    dr(S_AL, 8'hFD);
    dr(S_GEN, 8'h05);
    $display("search test done");
    print_verdict;
  end
endmodule
